/* design/tce_core.sv */
`timescale 1ns/1ps
module tce_core
  import tce_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         op_valid,
  input  wire tce_op_e      op_code,
  input  wire logic [7:0]   rd_data,
  output tce_mem_req_s      mem_req,
  output tce_regs_s         regs,
  output logic              op_busy,
  output logic              op_done
);

  // sequencer state and the op being worked on
  tce_state_e   state;
  tce_state_e   next_state;
  tce_op_e      op;
  tce_op_e      next_op;

  // next values of the registered outputs and the held low byte
  tce_regs_s    next_regs;
  tce_mem_req_s next_mem_req;
  logic [7:0]   lo_byte;
  logic [7:0]   next_lo_byte;
  logic         next_op_busy;
  logic         next_op_done;

  // memory timing: a read placed on mem_req must be answered on rd_data in
  // the same cycle, the byte is taken at the edge that ends the request
  // a write lands in memory at the edge that ends its request cycle
  // a slower memory would need a wait state added to every read state
  // busy low means the sequencer is idle and takes the next op, also in the
  // cycle where op_done is high; codes outside the group change no output
  // sequencer: one memory byte per state, outputs registered
  always_comb begin
    // hold every register, no request and no done unless a state says so
    next_state   = state;
    next_op      = op;
    next_regs    = regs;
    next_lo_byte = lo_byte;
    next_mem_req = '0;
    next_op_done = 1'b0;
    next_op_busy = op_busy;

    case (state)
      // idle: decode the op and place its first bus request
      TCE_ST_IDLE: begin
        if (op_valid) begin
          // remember the op; busy rises at the next edge, with the first request where the op has one
          next_op      = op_code;
          next_op_busy = 1'b1;
          next_state   = TCE_ST_DONE;
          case (op_code)
            // word fetch through the pointer
            TCE_OP_NEXT_WORD, TCE_OP_PTR_ILOAD: begin
              next_mem_req = '{req: 1'b1, we: 1'b0, addr: regs.tp, wdata: 8'h00};
              next_state   = TCE_ST_RD_LO;
            end

            // pointer takes the operand address, operand read from there
            TCE_OP_THR_JUMP: begin
              // pc still holds the opcode address here
              next_regs.tp = regs.pc + TCE_BYTE_STEP;
              next_mem_req = '{req: 1'b1, we: 1'b0, addr: regs.pc + TCE_BYTE_STEP, wdata: 8'h00};
              next_state   = TCE_ST_RD_LO;
            end

            // one byte through the pointer into the accumulator
            TCE_OP_ACC_ILOAD, TCE_OP_LOAD_ADV: begin
              next_mem_req = '{req: 1'b1, we: 1'b0, addr: regs.tp, wdata: 8'h00};
              next_state   = TCE_ST_RD_ACC;
            end

            // pointer step only, the bus stays quiet
            TCE_OP_PTR_INC: begin
              next_regs.tp = regs.tp + TCE_BYTE_STEP;
            end

            TCE_OP_PTR_PUSH: begin
              // high byte goes to the current stack slot first
              next_mem_req = '{req: 1'b1, we: 1'b1, addr: {TCE_STACK_PAGE, regs.sp},
                               wdata: regs.tp[15:8]};
              next_regs.sp = regs.sp - TCE_SP_STEP;
              next_state   = TCE_ST_WR_LO;
            end

            // pre-increment the stack pointer, read the low byte
            TCE_OP_PTR_PULL, TCE_OP_PULL_LOAD: begin
              next_regs.sp = regs.sp + TCE_SP_STEP;
              next_mem_req = '{req: 1'b1, we: 1'b0, addr: {TCE_STACK_PAGE, regs.sp + TCE_SP_STEP},
                               wdata: 8'h00};
              next_state   = TCE_ST_SP_LO;
            end

            // return from a threaded jump, no bus traffic
            TCE_OP_PTR_TO_PC: begin
              next_regs.pc = regs.tp;
            end

            // codes outside the group are dropped at once
            default: begin
              next_op_busy = 1'b0;
              next_state   = TCE_ST_IDLE;
            end
          endcase
        end
      end

      // low byte of a word, request the high byte at the next address
      TCE_ST_RD_LO: begin
        // read data answers the request that is on mem_req in this cycle
        next_lo_byte = rd_data;
        next_mem_req = '{req: 1'b1, we: 1'b0, addr: mem_req.addr + TCE_BYTE_STEP, wdata: 8'h00};
        next_state   = TCE_ST_RD_HI;
      end

      // high byte of a word: finish the load
      TCE_ST_RD_HI: begin
        if (op == TCE_OP_PTR_ILOAD) begin
          // pointer load takes the whole word
          next_regs.tp = {rd_data, lo_byte};
        end else begin
          // next-word and jump land in pc and step past the word
          next_regs.pc = {rd_data, lo_byte};
          next_regs.tp = regs.tp + TCE_PAIR_STEP;
        end
        next_state = TCE_ST_DONE;
      end

      // accumulator byte; the advancing ops step the pointer
      TCE_ST_RD_ACC: begin
        next_regs.acc = rd_data;
        if (op != TCE_OP_ACC_ILOAD) begin
          next_regs.tp = regs.tp + TCE_BYTE_STEP;
        end
        next_state = TCE_ST_DONE;
      end

      // second push byte: low half below the high half
      TCE_ST_WR_LO: begin
        // sp already points one below the high byte
        next_mem_req = '{req: 1'b1, we: 1'b1, addr: {TCE_STACK_PAGE, regs.sp},
                         wdata: regs.tp[7:0]};
        next_regs.sp = regs.sp - TCE_SP_STEP;
        next_state   = TCE_ST_DONE;
      end

      // low byte of the pulled word, read the high byte above it
      TCE_ST_SP_LO: begin
        // the stack stays in its page, sp wraps in 8 bits
        next_lo_byte = rd_data;
        next_regs.sp = regs.sp + TCE_SP_STEP;
        next_mem_req = '{req: 1'b1, we: 1'b0, addr: {TCE_STACK_PAGE, regs.sp + TCE_SP_STEP},
                         wdata: 8'h00};
        next_state   = TCE_ST_SP_HI;
      end

      // high byte of the pulled word; pull-and-load goes on to a byte read
      TCE_ST_SP_HI: begin
        next_regs.tp = {rd_data, lo_byte};
        if (op == TCE_OP_PULL_LOAD) begin
          // read the byte at the freshly pulled pointer
          next_mem_req = '{req: 1'b1, we: 1'b0, addr: {rd_data, lo_byte}, wdata: 8'h00};
          next_state   = TCE_ST_RD_ACC;
        end else begin
          next_state = TCE_ST_DONE;
        end
      end

      // one cycle of op_done, then back to idle
      TCE_ST_DONE: begin
        // the next op may be taken right after this edge
        next_op_done = 1'b1;
        next_op_busy = 1'b0;
        next_state   = TCE_ST_IDLE;
      end

      // unused state codes fall back to idle
      default: begin
        next_state   = TCE_ST_IDLE;
        next_op_busy = 1'b0;
      end
    endcase
  end

  // state and output registers; reset leaves the bus quiet
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // constants only: the idle register set
      state   <= TCE_ST_IDLE;
      op      <= TCE_OP_NONE;
      regs    <= '{pc: TCE_PC_RESET, tp: TCE_TP_RESET, sp: TCE_SP_RESET, acc: TCE_ACC_RESET};
      mem_req <= '0;
      lo_byte <= 8'h00;
      op_busy <= 1'b0;
      op_done <= 1'b0;
    end else begin
      // every register moves on each edge
      state   <= next_state;
      op      <= next_op;
      regs    <= next_regs;
      mem_req <= next_mem_req;
      lo_byte <= next_lo_byte;
      op_busy <= next_op_busy;
      op_done <= next_op_done;
    end
  end

endmodule

/* design/tce_pkg.sv */
package tce_pkg;

  // operation select codes for the threaded-code group
  typedef enum logic [3:0] {
    TCE_OP_NONE       = 4'h0,
    TCE_OP_NEXT_WORD  = 4'h1,
    TCE_OP_PTR_ILOAD  = 4'h2,
    TCE_OP_ACC_ILOAD  = 4'h3,
    TCE_OP_PTR_INC    = 4'h4,
    TCE_OP_PTR_PUSH   = 4'h5,
    TCE_OP_PTR_PULL   = 4'h6,
    TCE_OP_THR_JUMP   = 4'h7,
    TCE_OP_PTR_TO_PC  = 4'h8,
    TCE_OP_PULL_LOAD  = 4'h9,
    TCE_OP_LOAD_ADV   = 4'ha
  } tce_op_e;

  // sequencer states
  typedef enum logic [3:0] {
    TCE_ST_IDLE   = 4'h0,
    TCE_ST_RD_LO  = 4'h1,
    TCE_ST_RD_HI  = 4'h2,
    TCE_ST_RD_ACC = 4'h3,
    TCE_ST_WR_HI  = 4'h4,
    TCE_ST_WR_LO  = 4'h5,
    TCE_ST_SP_LO  = 4'h6,
    TCE_ST_SP_HI  = 4'h7,
    TCE_ST_DONE   = 4'h8
  } tce_state_e;

  // memory request toward program memory and stack RAM
  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } tce_mem_req_s;

  // architectural register set touched by the group
  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] tp;
    logic [7:0]  sp;
    logic [7:0]  acc;
  } tce_regs_s;

  localparam logic [15:0] TCE_PAIR_STEP  = 16'h0002;
  localparam logic [15:0] TCE_BYTE_STEP  = 16'h0001;
  localparam logic [7:0]  TCE_SP_STEP    = 8'h01;
  localparam logic [7:0]  TCE_STACK_PAGE = 8'h01;
  localparam logic [15:0] TCE_PC_RESET   = 16'h0000;
  localparam logic [15:0] TCE_TP_RESET   = 16'h0000;
  localparam logic [7:0]  TCE_SP_RESET   = 8'hff;
  localparam logic [7:0]  TCE_ACC_RESET  = 8'h00;

endpackage

/* tb/tce_mem_model.sv */
`timescale 1ns/1ps
module tce_mem_model
  import tce_pkg::*;
(
  input  wire logic         clk,
  input  wire tce_mem_req_s mem_req,
  output logic [7:0]        rd_data
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_rd;
  // a read is answered within its own request cycle, as the core takes it at the edge ending it
  assign rd_data = (mem_req.req && !mem_req.we) ? mem[mem_req.addr] : ~last_rd;
  // writes land at the edge ending the request; between reads the bus shows the inverse of the last byte
  always @(posedge clk) begin
    if (mem_req.req && mem_req.we)
      mem[mem_req.addr] <= mem_req.wdata;
    if (mem_req.req && !mem_req.we)
      last_rd <= mem[mem_req.addr];
  end
  initial last_rd = 8'h5a;
endmodule

/* tb/tce_core_sva.sv */
`timescale 1ns/1ps
module tce_core_sva
  import tce_pkg::*;
(
  input wire logic         clk,
  input wire logic         rst_b,
  input wire logic         op_valid,
  input wire tce_op_e      op_code,
  input wire logic [7:0]   rd_data,
  input wire tce_mem_req_s mem_req,
  input wire tce_regs_s    regs,
  input wire logic         op_busy,
  input wire logic         op_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic        tk;
  logic [15:0] tp;
  // a request taken while idle; busy low means the sequencer is idle
  assign tk = op_valid && !op_busy;
  assign tp = regs.tp;
  inc_step_a: assert property (tk && op_code == TCE_OP_PTR_INC |=> !mem_req.req
    ##1 op_done && tp == $past(tp, 2) + 16'h1) else $error("bad increment");
  to_pc_a: assert property (tk && op_code == TCE_OP_PTR_TO_PC |-> ##2 op_done && regs.pc == $past(tp, 2))
    else $error("bad transfer");
  word_order_a: assert property (tk && op_code == TCE_OP_PTR_ILOAD |=> mem_req.req && mem_req.addr == tp
    ##1 mem_req.req && mem_req.addr == tp + 16'h1) else $error("bad word order");
  next_word_a: assert property (tk && op_code == TCE_OP_NEXT_WORD |-> ##4 op_done
    && regs.pc == {$past(rd_data, 2), $past(rd_data, 3)} && tp == $past(tp, 4) + 16'h2) else $error("bad next");
  push_order_a: assert property (tk && op_code == TCE_OP_PTR_PUSH |=> mem_req.we
    && mem_req.addr == {8'h01, regs.sp + 8'h1} && mem_req.wdata == tp[15:8] ##1 mem_req.wdata == tp[7:0]
    ##1 op_done && regs.sp == $past(regs.sp, 3) - 8'h2) else $error("bad push");
  pull_a: assert property (tk && op_code == TCE_OP_PTR_PULL |-> ##4 op_done
    && tp == {$past(rd_data, 2), $past(rd_data, 3)} && regs.sp == $past(regs.sp, 4) + 8'h2) else $error("bad pull");
  jump_a: assert property (tk && op_code == TCE_OP_THR_JUMP |=> tp == $past(regs.pc) + 16'h1 ##3 op_done
    && regs.pc == {$past(rd_data, 2), $past(rd_data, 3)} && tp == $past(regs.pc, 4) + 16'h3) else $error("bad jump");
  load_adv_a: assert property (tk && op_code == TCE_OP_LOAD_ADV |-> ##3 op_done
    && regs.acc == $past(rd_data, 2) && tp == $past(tp, 3) + 16'h1) else $error("bad load");
endmodule
bind tce_core tce_core_sva u_sva (.clk(clk), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
  .rd_data(rd_data), .mem_req(mem_req), .regs(regs), .op_busy(op_busy), .op_done(op_done));

/* tb/tce_core_bench.sv */
`timescale 1ns/1ps
module tce_core_bench;
  import tce_pkg::*;
  logic         clk = 0;
  logic         rst_b = 0;
  logic         op_valid = 0;
  tce_op_e      op_code = TCE_OP_NONE;
  logic [7:0]   rd_data;
  tce_mem_req_s mem_req;
  tce_regs_s    regs;
  logic         op_busy;
  logic         op_done;
  int           n_fail = 0;
  int           samples_checked = 0;
  int           cyc = 0;
  tce_core dut (.clk(clk), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code), .rd_data(rd_data),
    .mem_req(mem_req), .regs(regs), .op_busy(op_busy), .op_done(op_done));
  tce_mem_model u_mem (.clk(clk), .mem_req(mem_req), .rd_data(rd_data));
  initial forever #2.5 clk = ~clk;
  // cycle ceiling against a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      n_fail = n_fail + 1;
      summarize();
    end
  end
  task automatic summarize();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(logic [47:0] got, logic [47:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // issue one operation, wait for done, compare the register set
  task automatic step(tce_op_e o, logic [15:0] pc, logic [15:0] tp, logic [7:0] sp, logic [7:0] acc);
    int i;
    op_valid = 1'b1;
    op_code = o;
    @(posedge clk) #1;
    op_valid = 1'b0;
    chk({47'h0, op_busy}, 48'h1);
    for (i = 0; i < 9 && op_done !== 1'b1; i++) @(posedge clk) #1;
    chk({46'h0, op_done, op_busy}, 48'h2);
    chk(regs, {pc, tp, sp, acc});
    @(posedge clk) #1;
  endtask
  task automatic t_ptr();
    step(TCE_OP_NEXT_WORD, 16'h1234, 16'h0002, 8'hff, 8'h00);
    step(TCE_OP_PTR_INC, 16'h1234, 16'h0003, 8'hff, 8'h00);
    step(TCE_OP_ACC_ILOAD, 16'h1234, 16'h0003, 8'hff, 8'ha5);
    step(TCE_OP_LOAD_ADV, 16'h1234, 16'h0004, 8'hff, 8'ha5);
    step(TCE_OP_PTR_ILOAD, 16'h1234, 16'hffff, 8'hff, 8'ha5);
    step(TCE_OP_LOAD_ADV, 16'h1234, 16'h0000, 8'hff, 8'h77);
    step(TCE_OP_PTR_ILOAD, 16'h1234, 16'h1234, 8'hff, 8'h77);
  endtask
  task automatic t_stack();
    step(TCE_OP_PTR_PUSH, 16'h1234, 16'h1234, 8'hfd, 8'h77);
    chk({32'h0, u_mem.mem[16'h01ff], u_mem.mem[16'h01fe]}, 48'h1234);
    step(TCE_OP_PTR_INC, 16'h1234, 16'h1235, 8'hfd, 8'h77);
    step(TCE_OP_PTR_PULL, 16'h1234, 16'h1234, 8'hff, 8'h77);
    step(TCE_OP_PTR_PUSH, 16'h1234, 16'h1234, 8'hfd, 8'h77);
    step(TCE_OP_PTR_INC, 16'h1234, 16'h1235, 8'hfd, 8'h77);
    step(TCE_OP_PULL_LOAD, 16'h1234, 16'h1235, 8'hff, 8'hc3);
  endtask
  task automatic t_jump();
    step(TCE_OP_PTR_TO_PC, 16'h1235, 16'h1235, 8'hff, 8'hc3);
    step(TCE_OP_THR_JUMP, 16'h5678, 16'h1238, 8'hff, 8'hc3);
  endtask
  initial begin
    u_mem.mem[16'h0000] = 8'h34;
    u_mem.mem[16'h0001] = 8'h12;
    u_mem.mem[16'h0003] = 8'ha5;
    u_mem.mem[16'h0004] = 8'hff;
    u_mem.mem[16'h0005] = 8'hff;
    u_mem.mem[16'hffff] = 8'h77;
    u_mem.mem[16'h1234] = 8'hc3;
    u_mem.mem[16'h1236] = 8'h78;
    u_mem.mem[16'h1237] = 8'h56;
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    chk(regs, {16'h0, 16'h0, 8'hff, 8'h00});
    t_ptr();
    t_stack();
    t_jump();
    summarize();
  end
endmodule
